// File: gcdc_gain_mult.sv
// gcdc_gain_mult: applies the gain code to each sample, one cycle latency, saturating
module gcdc_gain_mult
  import gcdc_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  gcdc_mul_if.mult_side mul
);
  localparam int unsigned PROD_W = SAMPLE_W + GAIN_W + 1;
  logic signed [PROD_W-1:0] product; // signed sample times unsigned gain
  logic signed [PROD_W-1:0] scaled; // product divided by 2^23
  logic signed [SAMPLE_W-1:0] nxt_result;
  logic signed [SAMPLE_W-1:0] result_ff;
  logic valid_ff;

  // gain is zero-extended so an upper bit set never reads as negative
  always_comb begin
    product = $signed({1'b0, mul.gain}) * mul.sample;
    scaled = product >>> GAIN_FRAC_BITS;
    // clip instead of wrapping: gains near two can overflow full-scale inputs
    if (&scaled[PROD_W-1:SAMPLE_W-1] || ~|scaled[PROD_W-1:SAMPLE_W-1]) begin
      nxt_result = scaled[SAMPLE_W-1:0];
    end else if (scaled[PROD_W-1]) begin
      nxt_result = {1'b1, {(SAMPLE_W-1){1'b0}}};
    end else begin
      nxt_result = {1'b0, {(SAMPLE_W-1){1'b1}}};
    end
  end

  // result register
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      result_ff <= '0;
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= mul.in_valid;
      if (mul.in_valid) begin
        result_ff <= nxt_result;
      end
    end
  end

  assign mul.out_valid = valid_ff;
  assign mul.result = result_ff;
endmodule // gcdc_gain_mult

// File: gcdc_if.sv
// gcdc_if: internal carriers for joined writes and the gain multiplier
interface gcdc_wr_if;
  logic strobe; // one-cycle pulse: a joined write is performed
  gcdc_pkg::gcdc_index_type index; // register index of the write
  logic [31:0] data; // write data
  logic [3:0] strb; // byte lanes
  logic hit; // index decodes to a writable register
  modport join_side (output strobe, output index, output data, output strb, input hit);
  modport reg_side (input strobe, input index, input data, input strb, output hit);
endinterface

interface gcdc_mul_if;
  logic in_valid; // sample present
  logic signed [gcdc_pkg::SAMPLE_W-1:0] sample; // raw conversion result
  logic [gcdc_pkg::GAIN_W-1:0] gain; // unsigned gain code
  logic out_valid; // corrected result present
  logic signed [gcdc_pkg::SAMPLE_W-1:0] result; // corrected result
  modport mult_side (input in_valid, input sample, input gain, output out_valid, output result);
  modport user_side (output in_valid, output sample, output gain, input out_valid, input result);
endinterface

// File: gcdc_pkg.sv
// gcdc_pkg: register indices, field layout, reset values and types for the gain/converter bank
package gcdc_pkg;
  // register index width; byte address is four times the index
  localparam int unsigned IDX_W = 6;
  localparam int unsigned ADDR_LSB = 2;
  typedef logic [IDX_W-1:0] gcdc_index_type;
  // printed register indices
  localparam gcdc_index_type IDX_GAIN_UPPER = 6'h11;
  localparam gcdc_index_type IDX_GAIN_LOWER = 6'h12;
  localparam gcdc_index_type IDX_CONV_CTRL = 6'h31;
  localparam gcdc_index_type IDX_MAP_CRC = 6'h3e;
  // extra status registers of this bank
  localparam gcdc_index_type IDX_STATUS = 6'h01;
  localparam gcdc_index_type IDX_LAST_RESULT = 6'h02;
  // reset values
  localparam logic [15:0] RST_GAIN_UPPER = 16'h8000;
  localparam logic [7:0] RST_GAIN_LOW_BITS = 8'h00;
  localparam logic [15:0] RST_CONV_CTRL = 16'h0000;
  localparam logic [15:0] RST_MAP_CRC = 16'h0000;
  // field positions
  localparam int unsigned GAIN_LOW_LSB = 8;
  localparam int unsigned CONV_EN_BIT = 0;
  localparam int unsigned BAND_LSB = 8;
  localparam int unsigned BAND_W = 4;
  // data path widths and gain scaling (code / 2^23)
  localparam int unsigned SAMPLE_W = 24;
  localparam int unsigned GAIN_W = 24;
  localparam int unsigned GAIN_FRAC_BITS = 23;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // read channel states
  typedef enum logic [1:0] {
    GCDC_RD_IDLE = 2'b00,
    GCDC_RD_RESP = 2'b01
  } gcdc_rd_state_type;
endpackage

// File: gcdc_regs.sv
// gcdc_regs: gain calibration, converter control and map checksum register bank
// Function
// R01: upper gain bits 23:8 at 0x11, read-write
// R02: lower gain bits 7:0 at 0x12[15:8]
// R03: gain code unsigned, range zero to near two
// R04: upper gain register resets to 0x8000
// R05: lower register resets zero, bits 7:0 read zero
// R06: band code in control bits 11:8
// R07: control bit 0 enables the converter
// R08: control at 0x31, reset zero, reserved written zero
// R09: checksum read-only at 0x3e, zero at reset
// R10: every sample multiplied by stored gain factor
// R11: gain equals code divided by 2^23
//
// Decided for this implementation: register access over AXI4-Lite.
module gcdc_regs
  import gcdc_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic clock_in,
  input wire logic reset_in,
  // axi4-lite write address channel
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic [2:0] s_axi_awprot_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // axi4-lite write data channel
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // axi4-lite write response channel
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read address channel
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic [2:0] s_axi_arprot_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // axi4-lite read data channel
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // raw conversion results
  input wire logic sample_valid_in,
  input wire logic signed [SAMPLE_W-1:0] sample_data_in,
  // gain corrected results
  output logic result_valid_out,
  output logic signed [SAMPLE_W-1:0] result_data_out,
  // register map checksum from the checksum engine
  input wire logic [15:0] map_crc_in,
  input wire logic map_crc_valid_in,
  // converter and gain controls
  output logic converter_enable_out,
  output logic [BAND_W-1:0] converter_band_code_out,
  output logic [GAIN_W-1:0] gain_factor_out
);
  import gcdc_pkg::*;

  // the index field must fit inside the byte address
  if (ADDR_W < IDX_W + ADDR_LSB) begin : g_addr_check
    $error("gcdc_regs: ADDR_W too small for the register map");
  end

  // decides whether an index names a readable register
  function automatic logic is_readable(input gcdc_index_type idx);
    is_readable = (idx == IDX_GAIN_UPPER) || (idx == IDX_GAIN_LOWER) ||
                  (idx == IDX_CONV_CTRL) || (idx == IDX_MAP_CRC) ||
                  (idx == IDX_STATUS) || (idx == IDX_LAST_RESULT);
  endfunction

  // decides whether an index names a writable register
  function automatic logic is_writable(input gcdc_index_type idx);
    is_writable = (idx == IDX_GAIN_UPPER) || (idx == IDX_GAIN_LOWER) ||
                  (idx == IDX_CONV_CTRL);
  endfunction

  // merges the two low byte lanes of a write into a 16-bit value
  function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                          input logic [31:0] new_val,
                                          input logic [3:0] strb);
    merge16[7:0] = strb[0] ? new_val[7:0] : old_val[7:0];
    merge16[15:8] = strb[1] ? new_val[15:8] : old_val[15:8];
  endfunction

  // register state
  logic [15:0] gain_factor_high_bits_ff; // gain code bits 23:8
  logic [7:0] gain_factor_low_bits_ff; // gain code bits 7:0
  logic [15:0] conv_ctrl_ff; // whole control word, reserved bits kept
  logic [15:0] map_crc_ff; // last checksum delivered
  logic signed [SAMPLE_W-1:0] last_result_ff; // last corrected sample
  logic [15:0] nxt_gain_high;
  logic [15:0] nxt_gain_low_word;
  logic [15:0] nxt_conv_ctrl;

  // read channel state
  gcdc_rd_state_type rd_state_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [31:0] nxt_rdata;
  gcdc_index_type rd_index;
  logic rd_take;

  // internal carriers
  gcdc_wr_if wr ();
  gcdc_mul_if mul ();

  // protection bits carry no meaning here; every access is served alike
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot_in, s_axi_arprot_in};

  // write address and data joining, write response
  gcdc_wr_join #(
    .ADDR_W(ADDR_W)
  ) u_wr_join (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .awaddr_in(s_axi_awaddr_in),
    .awvalid_in(s_axi_awvalid_in),
    .awready_out(s_axi_awready_out),
    .wdata_in(s_axi_wdata_in),
    .wstrb_in(s_axi_wstrb_in),
    .wvalid_in(s_axi_wvalid_in),
    .wready_out(s_axi_wready_out),
    .bresp_out(s_axi_bresp_out),
    .bvalid_out(s_axi_bvalid_out),
    .bready_in(s_axi_bready_in),
    .wr(wr.join_side)
  );

  // unmapped or read-only indices answer with an error response
  assign wr.hit = is_writable(wr.index);

  // next values for the writable registers, only enabled lanes change
  always_comb begin
    nxt_gain_high = merge16(gain_factor_high_bits_ff, wr.data, wr.strb);
    nxt_gain_low_word = merge16({gain_factor_low_bits_ff, 8'h00}, wr.data, wr.strb);
    nxt_conv_ctrl = merge16(conv_ctrl_ff, wr.data, wr.strb);
  end

  // upper gain register: full 16-bit read-write, mid-scale at reset
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      gain_factor_high_bits_ff <= RST_GAIN_UPPER; // see R04
    end else if (wr.strobe && wr.index == IDX_GAIN_UPPER) begin
      gain_factor_high_bits_ff <= nxt_gain_high; // see R01
    end
  end

  // lower gain register: only the upper byte is stored
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      gain_factor_low_bits_ff <= RST_GAIN_LOW_BITS; // see R05
    end else if (wr.strobe && wr.index == IDX_GAIN_LOWER) begin
      // low byte lane is dropped, those bits have no storage
      gain_factor_low_bits_ff <= nxt_gain_low_word[GAIN_LOW_LSB +: 8]; // see R02
    end
  end

  // converter control word, reserved bits stored as written
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      conv_ctrl_ff <= RST_CONV_CTRL; // see R08
    end else if (wr.strobe && wr.index == IDX_CONV_CTRL) begin
      // software is expected to keep reserved bits zero; nothing forces it
      conv_ctrl_ff <= nxt_conv_ctrl; // see R08
    end
  end

  // checksum register: only the checksum engine updates it
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      map_crc_ff <= RST_MAP_CRC; // see R09
    end else if (map_crc_valid_in) begin
      map_crc_ff <= map_crc_in; // see R09
    end
  end

  // converter outputs straight from the control flip-flops
  assign converter_enable_out = conv_ctrl_ff[CONV_EN_BIT]; // see R07
  // band code must match the modulator clock band; this bank only carries it
  assign converter_band_code_out = conv_ctrl_ff[BAND_LSB +: BAND_W]; // see R06

  // the assembled 24-bit unsigned code, mid-scale means a gain of one
  assign gain_factor_out = {gain_factor_high_bits_ff, gain_factor_low_bits_ff}; // see R03

  // gain correction data path
  assign mul.in_valid = sample_valid_in;
  assign mul.sample = sample_data_in;
  assign mul.gain = gain_factor_out; // see R10

  // one-cycle multiplier; a gain change applies from the next sample taken
  gcdc_gain_mult u_gain_mult (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .mul(mul.mult_side)
  ); // see R11

  assign result_valid_out = mul.out_valid; // see R10
  assign result_data_out = mul.result;

  // keeps the latest corrected sample visible to software
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      last_result_ff <= '0;
    end else if (mul.out_valid) begin
      last_result_ff <= mul.result;
    end
  end

  // read path: one request at a time, answered the cycle after it is taken
  assign rd_index = s_axi_araddr_in[ADDR_LSB +: IDX_W];
  assign s_axi_arready_out = (rd_state_ff == GCDC_RD_IDLE);
  assign rd_take = s_axi_arvalid_in && s_axi_arready_out;

  // read data selection, narrow registers sit in the low bits
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (rd_index)
      IDX_GAIN_UPPER: begin
        nxt_rdata[15:0] = gain_factor_high_bits_ff; // see R01
      end
      IDX_GAIN_LOWER: begin
        // reserved low byte always reads zero
        nxt_rdata[15:0] = {gain_factor_low_bits_ff, 8'h00}; // see R05
      end
      IDX_CONV_CTRL: begin
        nxt_rdata[15:0] = conv_ctrl_ff;
      end
      IDX_MAP_CRC: begin
        nxt_rdata[15:0] = map_crc_ff; // see R09
      end
      IDX_STATUS: begin
        nxt_rdata[15:0] = {11'h000, converter_band_code_out, converter_enable_out};
      end
      IDX_LAST_RESULT: begin
        nxt_rdata[SAMPLE_W-1:0] = last_result_ff;
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  // read channel state machine
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      rd_state_ff <= GCDC_RD_IDLE;
    end else begin
      unique case (rd_state_ff)
        GCDC_RD_IDLE: begin
          if (rd_take) begin
            rd_state_ff <= GCDC_RD_RESP;
          end
        end
        GCDC_RD_RESP: begin
          if (s_axi_rready_in) begin
            rd_state_ff <= GCDC_RD_IDLE;
          end
        end
        default: begin
          rd_state_ff <= GCDC_RD_IDLE;
        end
      endcase
    end
  end

  // read data and response captured when the address is taken
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else if (rd_take) begin
      rdata_ff <= is_readable(rd_index) ? nxt_rdata : 32'h0000_0000;
      rresp_ff <= is_readable(rd_index) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  assign s_axi_rvalid_out = (rd_state_ff == GCDC_RD_RESP);
  assign s_axi_rdata_out = rdata_ff;
  assign s_axi_rresp_out = rresp_ff;
endmodule // gcdc_regs

// File: gcdc_regs_properties.sv
// gcdc_regs_properties: port-level checks for the gain/converter register bank
module gcdc_regs_properties
  import gcdc_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic sample_valid_in,
  input wire logic result_valid_out,
  input wire logic signed [SAMPLE_W-1:0] result_data_out,
  input wire logic [15:0] map_crc_in,
  input wire logic map_crc_valid_in,
  input wire logic converter_enable_out,
  input wire logic [BAND_W-1:0] converter_band_code_out,
  input wire logic [GAIN_W-1:0] gain_factor_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  logic [ADDR_W-1:0] rd_addr_ff; // address of the read in flight
  logic [15:0] crc_ff; // last checksum handed in, zero after reset
  // shadow the read address and checksum so read data can be judged
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      rd_addr_ff <= '0;
      crc_ff <= 16'h0000;
    end else begin
      if (s_axi_arvalid_in && s_axi_arready_out) rd_addr_ff <= s_axi_araddr_in;
      if (map_crc_valid_in) crc_ff <= map_crc_in;
    end
  end
  sequence s_aw_w_taken;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  property p_write_answer; s_aw_w_taken |-> ##1 !s_axi_bvalid_out ##1 s_axi_bvalid_out; endproperty
  a_write_answer: assert property (p_write_answer) else $error("late write answer");
  property p_b_refuse; s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out; endproperty
  a_b_refuse: assert property (p_b_refuse) else $error("write taken during answer");
  property p_b_done; s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out; endproperty
  a_b_done: assert property (p_b_done) else $error("write answer stuck");
  property p_r_answer; s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out; endproperty
  a_r_answer: assert property (p_r_answer) else $error("late read answer");
  property p_r_refuse; s_axi_rvalid_out |-> !s_axi_arready_out; endproperty
  a_r_refuse: assert property (p_r_refuse) else $error("read taken during answer");
  // controls may only move at the edge that completes a write
  property p_ctrl_on_write;
    $changed({converter_enable_out, converter_band_code_out, gain_factor_out})
      |-> $rose(s_axi_bvalid_out);
  endproperty
  a_ctrl_on_write: assert property (p_ctrl_on_write) else $error("control moved alone");
  property p_reset_vals;
    $fell(reset_in) |-> gain_factor_out == 24'h800000 && !converter_enable_out
      && converter_band_code_out == 4'h0;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
  property p_low_reserved; s_axi_rvalid_out && rd_addr_ff == 'h48 |-> s_axi_rdata_out[7:0] == 8'h00;
  endproperty
  a_low_reserved: assert property (p_low_reserved) else $error("reserved bits set");
  property p_crc_read; s_axi_rvalid_out && rd_addr_ff == 'hf8 |-> s_axi_rdata_out == {16'h0, crc_ff};
  endproperty
  a_crc_read: assert property (p_crc_read) else $error("checksum read wrong");
  property p_result_pulse; sample_valid_in |=> result_valid_out; endproperty
  a_result_pulse: assert property (p_result_pulse) else $error("result missing");
  property p_result_quiet; !sample_valid_in |=> !result_valid_out && $stable(result_data_out);
  endproperty
  a_result_quiet: assert property (p_result_quiet) else $error("result not held");
endmodule // gcdc_regs_properties

bind gcdc_regs gcdc_regs_properties #(.ADDR_W(ADDR_W)) u_props (.clock_in, .reset_in,
  .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
  .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
  .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rvalid_out, .s_axi_rready_in,
  .sample_valid_in, .result_valid_out, .result_data_out, .map_crc_in, .map_crc_valid_in,
  .converter_enable_out, .converter_band_code_out, .gain_factor_out);

// File: gcdc_regs_tb_top.sv
// gcdc_regs_tb_top: randomised self-checking bench for the gain/converter bank
`define CHK(act, exp, msg) begin samples_checked++; if ((act) !== (exp)) begin fail_count++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module gcdc_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gcdc_pkg::*;
  logic clock_in = 1'b0, reset_in = 1'b1;
  logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0] s_axi_wstrb_in = 4'hf;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_arvalid_in = 1'b0;
  logic s_axi_bready_in = 1'b1, s_axi_rready_in = 1'b1; // always willing to take answers
  logic sample_valid_in = 1'b0, map_crc_valid_in = 1'b0;
  logic signed [23:0] sample_data_in = 24'h0;
  logic [15:0] map_crc_in = 16'h0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, result_valid_out, converter_enable_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [31:0] s_axi_rdata_out;
  logic signed [23:0] result_data_out;
  logic [3:0] converter_band_code_out;
  logic [23:0] gain_factor_out;
  int fail_count = 0, samples_checked = 0;
  logic [23:0] gain_m = 24'h800000; // expected gain code
  gcdc_regs #(.ADDR_W(8)) dut (.clock_in, .reset_in, .s_axi_awaddr_in, .s_axi_awprot_in(3'b000),
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
    .s_axi_arprot_in(3'b000), .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .sample_valid_in, .sample_data_in,
    .result_valid_out, .result_data_out, .map_crc_in, .map_crc_valid_in, .converter_enable_out,
    .converter_band_code_out, .gain_factor_out);
  always #4 clock_in = ~clock_in;
  // gain is code / 2^23, clipped to the signed 24-bit range
  function automatic logic signed [23:0] scale(input logic signed [23:0] s, input logic [23:0] g);
    longint p;
    p = (longint'(s) * longint'(g)) >>> 23;
    if (p > 64'sd8388607) p = 64'sd8388607;
    if (p < -64'sd8388608) p = -64'sd8388608;
    return 24'(p);
  endfunction
  // one write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge clock_in); // an idle edge keeps valid from being reassigned in one step
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    // no cycle limit of its own: only the watchdog ends a stalled wait
    do begin
      #1;
      ta = s_axi_awvalid_in && s_axi_awready_out;
      tw = s_axi_wvalid_in && s_axi_wready_out;
      tb = s_axi_bvalid_out;
      r = s_axi_bresp_out;
      @(posedge clock_in);
      if (ta) s_axi_awvalid_in <= 1'b0;
      if (tw) s_axi_wvalid_in <= 1'b0;
    end while (!tb);
    `CHK(r, er, "write response")
  endtask
  // one read, compared against the expected word and response
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clock_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    do begin
      #1;
      ta = s_axi_arvalid_in && s_axi_arready_out;
      tr = s_axi_rvalid_out;
      d = s_axi_rdata_out;
      r = s_axi_rresp_out;
      @(posedge clock_in);
      if (ta) s_axi_arvalid_in <= 1'b0;
    end while (!tr);
    `CHK(d, ed, "read data")
    `CHK(r, er, "read response")
  endtask
  // one sample; the corrected result shows one edge later
  task automatic smp(input logic signed [23:0] s);
    sample_data_in <= s;
    sample_valid_in <= 1'b1;
    @(posedge clock_in);
    sample_valid_in <= 1'b0;
    #1;
    `CHK(result_valid_out, 1'b1, "result strobe")
    `CHK(result_data_out, scale(s, gain_m), "scaled result")
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 2000 edges
  initial begin
    repeat (20000) @(posedge clock_in);
    fail_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    complete_run();
  end
  initial begin
    logic [15:0] u, c;
    logic [7:0] l;
    void'($urandom(2));
    repeat (5) @(posedge clock_in);
    reset_in <= 1'b0;
    rd(8'h44, 32'h8000, RESP_OKAY);
    rd(8'h48, 32'h0, RESP_OKAY);
    rd(8'hc4, 32'h0, RESP_OKAY);
    rd(8'hf8, 32'h0, RESP_OKAY);
    `CHK(gain_factor_out, 24'h800000, "gain reset")
    smp(24'sh123456);
    $display("test reset values done");
    // corners at passes 0 and 2: full-scale gain, then zero gain; random codes in the other passes
    for (int i = 0; i < 10; i++) begin
      u = (i == 0) ? 16'hffff : (i == 2) ? 16'h0 : 16'($urandom);
      l = (i == 0) ? 8'hff : (i == 2) ? 8'h0 : 8'($urandom);
      wr(8'h44, {16'h0, u}, RESP_OKAY);
      wr(8'h48, {16'h0, l, 8'($urandom)}, RESP_OKAY);
      gain_m = {u, l};
      rd(8'h44, {16'h0, u}, RESP_OKAY);
      rd(8'h48, {16'h0, l, 8'h00}, RESP_OKAY);
      `CHK(gain_factor_out, gain_m, "gain out")
      smp((i == 0) ? 24'sh7fffff : 24'($urandom));
      smp((i == 1) ? 24'sh800000 : 24'($urandom));
    end
    // a write with only the high byte lane enabled leaves the low byte alone
    s_axi_wstrb_in <= 4'h2;
    wr(8'h44, 32'h0000_5a00, RESP_OKAY);
    s_axi_wstrb_in <= 4'hf;
    rd(8'h44, {16'h0, 8'h5a, u[7:0]}, RESP_OKAY);
    $display("test gain done");
    // every band code, enable toggling with the code's low bit
    for (int b = 0; b < 16; b++) begin
      c = {4'h0, 4'(b), 7'h0, 1'(b)};
      wr(8'hc4, {16'h0, c}, RESP_OKAY);
      rd(8'hc4, {16'h0, c}, RESP_OKAY);
      `CHK({converter_band_code_out, converter_enable_out}, {4'(b), 1'(b)}, "ctrl")
    end
    // status mirrors the last control word: band 0xf, converter on
    rd(8'h04, 32'h0000_001f, RESP_OKAY);
    $display("test converter done");
    c = 16'($urandom);
    map_crc_in <= c;
    map_crc_valid_in <= 1'b1;
    @(posedge clock_in);
    map_crc_valid_in <= 1'b0;
    rd(8'hf8, {16'h0, c}, RESP_OKAY);
    wr(8'hf8, 32'ha5a5, RESP_SLVERR);
    rd(8'hf8, {16'h0, c}, RESP_OKAY);
    wr(8'h80, 32'h1, RESP_SLVERR);
    rd(8'h80, 32'h0, RESP_SLVERR);
    $display("test checksum done");
    // a second reset in mid-run must restore the defaults
    reset_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    gain_m = 24'h800000;
    rd(8'hc4, 32'h0, RESP_OKAY);
    rd(8'h44, 32'h8000, RESP_OKAY);
    smp(24'sh400000);
    rd(8'h08, 32'h0040_0000, RESP_OKAY);
    $display("test reset again done");
    complete_run();
  end
endmodule // gcdc_regs_tb_top

// File: gcdc_wr_join.sv
// gcdc_wr_join: axi-lite write address/data joiner and write response channel
module gcdc_wr_join
  import gcdc_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [ADDR_W-1:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  gcdc_wr_if.join_side wr
);
  logic aw_held_ff; // address captured, waiting for data
  logic w_held_ff; // data captured, waiting for address
  logic [ADDR_W-1:0] addr_ff;
  logic [31:0] data_ff;
  logic [3:0] strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;

  // each channel accepts only while its holding slot is free and no response waits
  assign awready_out = !aw_held_ff && !bvalid_ff;
  assign wready_out = !w_held_ff && !bvalid_ff;
  assign wr.strobe = aw_held_ff && w_held_ff;
  assign wr.index = addr_ff[ADDR_LSB +: IDX_W];
  assign wr.data = data_ff;
  assign wr.strb = strb_ff;

  // capture address and data in either order, then retire them together
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      addr_ff <= '0;
      data_ff <= '0;
      strb_ff <= '0;
    end else if (wr.strobe) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
    end else begin
      if (awvalid_in && awready_out) begin
        aw_held_ff <= 1'b1;
        addr_ff <= awaddr_in;
      end
      if (wvalid_in && wready_out) begin
        w_held_ff <= 1'b1;
        data_ff <= wdata_in;
        strb_ff <= wstrb_in;
      end
    end
  end

  // response one cycle after the write is performed, held until bready
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr.strobe) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr.hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready_in) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign bvalid_out = bvalid_ff;
  assign bresp_out = bresp_ff;
endmodule // gcdc_wr_join
